// file: logic/prdm_defs.svh
`ifndef PRDM_DEFS_SVH
`define PRDM_DEFS_SVH

// register byte offsets on the apb bus
`define PRDM_OFS_CONTROL   12'h000
`define PRDM_OFS_SEED      12'h004
`define PRDM_OFS_SEED_COPY 12'h008
`define PRDM_OFS_POLY      12'h00C
`define PRDM_OFS_DENS_A    12'h010
`define PRDM_OFS_DENS_B    12'h014
`define PRDM_OFS_STATUS    12'h018

// control field positions
`define PRDM_CTRL_RUN      0
`define PRDM_CTRL_SENSE_A  1
`define PRDM_CTRL_SENSE_B  2

// status field positions
`define PRDM_STAT_RUNNING  0
`define PRDM_STAT_DEN_A    1
`define PRDM_STAT_DEN_B    2

// build-time defaults for the 8-bit resolution
`define PRDM_RES_DEFAULT   8
`define PRDM_POLY_DEFAULT  32'h0000_00B8
`define PRDM_SEED_DEFAULT  32'h0000_00FF
`define PRDM_DENS_DEFAULT  32'h0000_0080

`endif

// file: logic/prdm_pkg.sv
package prdm_pkg;
  // compare sense of one density channel
  typedef enum logic {
    PRDM_AT_OR_BELOW,
    PRDM_AT_OR_ABOVE
  } prdm_sense_e;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } prdm_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } prdm_apb_rsp_s;

  // synchronised external control levels
  typedef struct packed {
    logic enable;
    logic reset;
    logic kill;
  } prdm_ctl_s;
endpackage

// file: logic/prdm_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module prdm_sync
  import prdm_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire prdm_ctl_s pinIn,
  output prdm_ctl_s      syncOut
);
  prdm_ctl_s stage1_reg;
  prdm_ctl_s stage2_reg;

  // first stage feeds only the second one
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule

// file: logic/prdm_top.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "prdm_defs.svh"
// Overview of operation
// - Once software sets the run bit and the enable pin is high the sequence advances on each rising clock edge.
// - Clearing the run bit halts the sequence; density and serial outputs keep their present value and the terminal count pulse goes low.
// - Channel A at-or-below drives density_out_a high when sequence <= threshold A.
// - Channel A at-or-above drives density_out_a high when sequence >= threshold A.
// - Channel B at-or-below drives density_out_b high when sequence <= threshold B.
// - Channel B at-or-above drives density_out_b high when sequence >= threshold B.
// - With fixed compare sense there is no software stop and no runtime sense change.
// - Writing the seed loads the generator start value; reads return the live sequence at the resolution width.
// - The polynomial register is readable and writable at the resolution width.
// - Each density threshold accepts writes at any time and reads back its value.
// - While kill is high on a started block both density outputs are low; they resume when it drops.
// - While the block is started the serial output shows the shift register least significant bit.
// - While the reset input is high on a started block the sequence reloads the start value.
// - For 8 and 16 bit lengths the terminal count pulses one cycle at all ones.
module prdm_top
  import prdm_pkg::*;
#(
  parameter int          RES         = `PRDM_RES_DEFAULT,
  parameter bit          FIXED_SENSE = 1'b0,
  parameter logic [31:0] POLY_INIT   = `PRDM_POLY_DEFAULT,
  parameter logic [31:0] SEED_INIT   = `PRDM_SEED_DEFAULT,
  parameter logic [31:0] DENS_A_INIT = `PRDM_DENS_DEFAULT,
  parameter logic [31:0] DENS_B_INIT = `PRDM_DENS_DEFAULT,
  parameter prdm_sense_e SENSE_A_INIT = PRDM_AT_OR_BELOW,
  parameter prdm_sense_e SENSE_B_INIT = PRDM_AT_OR_BELOW
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enablePin,
  input  wire logic        seqResetPin,
  input  wire logic        killPin,
  output logic             density_out_a,
  output logic             density_out_b,
  output logic             serialBit,
  output logic             terminal_count_pulse
);
  localparam logic [RES-1:0] ALL_ONES = '1;

  prdm_apb_req_s apbReq;
  prdm_ctl_s     pinBundle;
  prdm_ctl_s     ctl;

  logic [RES-1:0] seq_reg;
  logic [RES-1:0] seq_next;
  logic [RES-1:0] seedCopy_reg;
  logic [RES-1:0] poly_reg;
  logic [RES-1:0] densA_reg;
  logic [RES-1:0] densB_reg;
  logic           run_reg;
  prdm_sense_e    senseA_reg;
  prdm_sense_e    senseB_reg;
  logic [31:0]    prdata_next;
  logic           pslverr_next;

  // apb request bundle
  assign apbReq = '{psel: psel, penable: penable, pwrite: pwrite,
                    paddr: paddr, pwdata: pwdata};

  // enable, reset and kill come from pins and are resynchronised
  assign pinBundle = '{enable: enablePin, reset: seqResetPin, kill: killPin};

  prdm_sync u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (pinBundle),
    .syncOut (ctl)
  );

  // address decode, shared by write and read paths
  function automatic logic hitReg(input logic [11:0] addr, input logic [11:0] ofs);
    hitReg = (addr == ofs);
  endfunction

  wire accessPhase = apbReq.psel & apbReq.penable;
  wire wrStrobe    = accessPhase & apbReq.pwrite;
  wire wrCtrl      = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_CONTROL);
  wire wrSeed      = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_SEED);
  wire wrSeedCopy  = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_SEED_COPY);
  wire wrPoly      = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_POLY);
  wire wrDensA     = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_DENS_A);
  wire wrDensB     = wrStrobe & hitReg(apbReq.paddr, `PRDM_OFS_DENS_B);
  wire [RES-1:0] wrVal = apbReq.pwdata[RES-1:0];

  wire mapped = hitReg(apbReq.paddr, `PRDM_OFS_CONTROL)
              | hitReg(apbReq.paddr, `PRDM_OFS_SEED)
              | hitReg(apbReq.paddr, `PRDM_OFS_SEED_COPY)
              | hitReg(apbReq.paddr, `PRDM_OFS_POLY)
              | hitReg(apbReq.paddr, `PRDM_OFS_DENS_A)
              | hitReg(apbReq.paddr, `PRDM_OFS_DENS_B)
              | hitReg(apbReq.paddr, `PRDM_OFS_STATUS);

  // the generator moves only when software runs it and the enable pin is high
  wire started  = run_reg;
  wire advance  = started & ctl.enable & ~ctl.reset;
  wire reloadSq = started & ctl.reset;

  // galois step: shift right, xor the polynomial in when the lsb falls out
  assign seq_next = seq_reg[0] ? ((seq_reg >> 1) ^ poly_reg) : (seq_reg >> 1);

  // next sequence value: software write wins, then pin reload, then advance
  wire [RES-1:0] seqLoad = wrSeed   ? wrVal :
                           reloadSq ? seedCopy_reg :
                           advance  ? seq_next : seq_reg;

  // unsigned full-width compares of the current sequence value
  wire belowA  = (seq_reg <= densA_reg);
  wire aboveA  = (seq_reg >= densA_reg);
  wire belowB  = (seq_reg <= densB_reg);
  wire aboveB  = (seq_reg >= densB_reg);
  wire cmpA    = (senseA_reg == PRDM_AT_OR_BELOW) ? belowA : aboveA;
  wire cmpB    = (senseB_reg == PRDM_AT_OR_BELOW) ? belowB : aboveB;
  wire tcMatch = ((RES == 8) || (RES == 16)) && (seq_reg == ALL_ONES);

  // control register; with a fixed sense the run bit is set once and never cleared
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      run_reg    <= 1'b0;
      senseA_reg <= SENSE_A_INIT;
      senseB_reg <= SENSE_B_INIT;
    end
    else if (wrCtrl)
    begin
      if (FIXED_SENSE)
        run_reg <= run_reg | apbReq.pwdata[`PRDM_CTRL_RUN];
      else
      begin
        run_reg    <= apbReq.pwdata[`PRDM_CTRL_RUN];
        senseA_reg <= prdm_sense_e'(apbReq.pwdata[`PRDM_CTRL_SENSE_A]);
        senseB_reg <= prdm_sense_e'(apbReq.pwdata[`PRDM_CTRL_SENSE_B]);
      end
    end
  end

  // configuration registers, writable at any time
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      poly_reg     <= POLY_INIT[RES-1:0];
      densA_reg    <= DENS_A_INIT[RES-1:0];
      densB_reg    <= DENS_B_INIT[RES-1:0];
      seedCopy_reg <= SEED_INIT[RES-1:0];
    end
    else
    begin
      if (wrPoly)
        poly_reg <= wrVal;
      if (wrDensA)
        densA_reg <= wrVal;
      if (wrDensB)
        densB_reg <= wrVal;
      if (wrSeed || wrSeedCopy)
        seedCopy_reg <= wrVal;
    end
  end

  // sequence register takes the shared next-value mux
  always_ff @(posedge clk)
  begin
    if (!rstn)
      seq_reg <= SEED_INIT[RES-1:0];
    else
      seq_reg <= seqLoad;
  end

  // density and serial outputs update only while started, so a stop freezes them; terminal count clears
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      density_out_a        <= 1'b0;
      density_out_b        <= 1'b0;
      serialBit            <= 1'b0;
      terminal_count_pulse <= 1'b0;
    end
    else if (started)
    begin
      density_out_a        <= cmpA & ~ctl.kill;
      density_out_b        <= cmpB & ~ctl.kill;
      serialBit            <= seqLoad[0];           // same edge as seq_reg, no lag
      terminal_count_pulse <= tcMatch & advance;
    end
    else
    begin
      terminal_count_pulse <= 1'b0;
    end
  end

  // read mux; status shows the live run state and output levels
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (hitReg(apbReq.paddr, `PRDM_OFS_CONTROL))
    begin
      prdata_next[`PRDM_CTRL_RUN]     = run_reg;
      prdata_next[`PRDM_CTRL_SENSE_A] = senseA_reg;
      prdata_next[`PRDM_CTRL_SENSE_B] = senseB_reg;
    end
    else if (hitReg(apbReq.paddr, `PRDM_OFS_SEED))
      prdata_next[RES-1:0] = seq_reg;
    else if (hitReg(apbReq.paddr, `PRDM_OFS_SEED_COPY))
      prdata_next[RES-1:0] = seedCopy_reg;
    else if (hitReg(apbReq.paddr, `PRDM_OFS_POLY))
      prdata_next[RES-1:0] = poly_reg;
    else if (hitReg(apbReq.paddr, `PRDM_OFS_DENS_A))
      prdata_next[RES-1:0] = densA_reg;
    else if (hitReg(apbReq.paddr, `PRDM_OFS_DENS_B))
      prdata_next[RES-1:0] = densB_reg;
    else if (hitReg(apbReq.paddr, `PRDM_OFS_STATUS))
    begin
      prdata_next[`PRDM_STAT_RUNNING] = advance;
      prdata_next[`PRDM_STAT_DEN_A]   = density_out_a;
      prdata_next[`PRDM_STAT_DEN_B]   = density_out_b;
    end
  end

  assign pslverr_next = ~mapped;

  // registered answer: setup cycle loads data, access cycle sees pready high
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbReq.psel & ~apbReq.penable;
      prdata  <= (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite) ? prdata_next : 32'h0000_0000;
      pslverr <= apbReq.psel & ~apbReq.penable & pslverr_next;
    end
  end
endmodule

// file: bench/prdm_top_sva.sv
`timescale 1ns/1ps
`include "prdm_defs.svh"
// protocol and output checks seen from the top ports only
module prdm_top_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        killPin,
  input wire logic        density_out_a,
  input wire logic        density_out_b,
  input wire logic        terminal_count_pulse
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // slave answers in the first access cycle, without wait states
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_unmapped_err: assert property (pready && paddr > `PRDM_OFS_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr <= `PRDM_OFS_STATUS && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("mapped access refused");
  // sync delay is three edges, so five high samples cover it
  a_kill_low: assert property (killPin [*5] |-> !$rose(density_out_a) && !$rose(density_out_b))
    else $error("density rose under kill");
  a_tc_spacing: assert property (terminal_count_pulse |=> !terminal_count_pulse [*8])
    else $error("terminal count too close");
endmodule

bind prdm_top prdm_top_sva prdm_top_sva_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .killPin(killPin), .density_out_a(density_out_a), .density_out_b(density_out_b),
  .terminal_count_pulse(terminal_count_pulse));

// file: bench/tb.sv
`timescale 1ns/1ps
`include "prdm_defs.svh"
// self-checking bench for the density modulator
module tb;
  import prdm_pkg::*;
  localparam int RES = 8;
  logic        clk, rstn, psel, penable, pwrite, enablePin, seqResetPin, killPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2, sd;
  logic        pready, pslverr, density_out_a, density_out_b, serialBit;
  logic        terminal_count_pulse, er, a0;
  int          errorCnt = 0;
  int          numChecks = 0;
  int          ca, cb, ct;
  logic [11:0] ofs [3] = '{`PRDM_OFS_POLY, `PRDM_OFS_DENS_A, `PRDM_OFS_DENS_B};

  prdm_top prdm_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enablePin(enablePin), .seqResetPin(seqResetPin), .killPin(killPin),
    .density_out_a(density_out_a), .density_out_b(density_out_b), .serialBit(serialBit),
    .terminal_count_pulse(terminal_count_pulse));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // register width keeps only the low resolution bits
  function automatic logic [31:0] fit(input logic [31:0] v);
    return v & ((32'h0000_0001 << RES) - 1);
  endfunction

  // one galois step with the default polynomial, shifting towards the lsb
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return fit(v[0] ? ((v >> 1) ^ `PRDM_POLY_DEFAULT) : (v >> 1));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // counts high cycles of both densities and terminal count
  task automatic cnt(input int n);
    ca = 0;
    cb = 0;
    ct = 0;
    repeat (n)
    begin
      @(posedge clk);
      ca += (density_out_a === 1'b1);
      cb += (density_out_b === 1'b1);
      ct += (terminal_count_pulse === 1'b1);
    end
  endtask

  task automatic endSim;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    endSim;
  end

  initial
  begin
    {psel, penable, pwrite, enablePin, seqResetPin, killPin} = '0;
    paddr = '0;
    pwdata = '0;
    rstn = 1'b0;
    sd = $urandom(32'hdb1b);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    enablePin <= 1'b1;
    rdc(`PRDM_OFS_CONTROL, 32'h0000_0000);
    rdc(`PRDM_OFS_SEED, 32'h0000_00FF);
    rdc(`PRDM_OFS_POLY, 32'h0000_00B8);
    rdc(`PRDM_OFS_DENS_A, 32'h0000_0080);
    rdc(`PRDM_OFS_DENS_B, 32'h0000_0080);
    $display("test 1 done");
    for (int i = 0; i < 3; i++)
    begin
      sd = $urandom;
      apb(1'b1, ofs[i], sd);
      rdc(ofs[i], fit(sd));
    end
    apb(1'b1, 12'h100, $urandom);
    chk(er, 1'b1);
    rdc(12'h100, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b1, `PRDM_OFS_POLY, 32'h0000_00B8);
    $display("test 2 done");
    // seed written while stopped, so the live value must read back
    sd = fit($urandom) | 32'h0000_0001;
    apb(1'b1, `PRDM_OFS_SEED, sd);
    rdc(`PRDM_OFS_SEED, sd);
    rdc(`PRDM_OFS_SEED_COPY, sd);
    $display("test 3 done");
    // extreme thresholds make the density counts exact
    apb(1'b1, `PRDM_OFS_DENS_A, 32'h0000_00FF);
    apb(1'b1, `PRDM_OFS_DENS_B, 32'h0000_0000);
    apb(1'b1, `PRDM_OFS_CONTROL, 32'h0000_0005);
    apb(1'b0, `PRDM_OFS_SEED, 32'h0000_0000);
    rd2 = rd;
    // back-to-back reads sample the sequence three edges apart
    apb(1'b0, `PRDM_OFS_SEED, 32'h0000_0000);
    chk(rd, lfsr(lfsr(lfsr(rd2))));
    repeat (4) @(posedge clk);
    cnt(510);
    chk(ca, 510);
    chk(cb, 510);
    chk(ct, 2);
    $display("test 4 done");
    killPin <= 1'b1;
    repeat (4) @(posedge clk);
    cnt(20);
    chk(ca + cb, 0);
    killPin <= 1'b0;
    repeat (4) @(posedge clk);
    cnt(20);
    chk(ca + cb, 40);
    $display("test 5 done");
    apb(1'b1, `PRDM_OFS_CONTROL, 32'h0000_0003);
    repeat (4) @(posedge clk);
    cnt(510);
    chk(ca, 2);
    chk(cb, 0);
    $display("test 6 done");
    seqResetPin <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(`PRDM_OFS_SEED, sd);
    seqResetPin <= 1'b0;
    $display("test 7 done");
    // stopped block must freeze sequence and density A, keep serial bit on the lsb and terminal count low
    apb(1'b1, `PRDM_OFS_CONTROL, 32'h0000_0002);
    apb(1'b0, `PRDM_OFS_SEED, 32'h0000_0000);
    rd2 = rd;
    chk(serialBit, rd2[0]);
    a0 = density_out_a;
    repeat (30) @(posedge clk);
    rdc(`PRDM_OFS_SEED, rd2);
    cnt(20);
    chk(ca, a0 ? 20 : 0);
    chk(ct, 0);
    $display("test 8 done");
    // sleep and wake: restored setup reruns only if the saved run bit was set
    apb(1'b0, `PRDM_OFS_CONTROL, 32'h0000_0000);
    rd2 = rd;
    apb(1'b1, `PRDM_OFS_CONTROL, rd2);
    repeat (4) @(posedge clk);
    apb(1'b0, `PRDM_OFS_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b0);
    apb(1'b1, `PRDM_OFS_CONTROL, 32'h0000_0003);
    apb(1'b0, `PRDM_OFS_CONTROL, 32'h0000_0000);
    rd2 = rd;
    chk(rd2, 32'h0000_0003);
    apb(1'b1, `PRDM_OFS_CONTROL, rd2 & 32'h0000_0006);
    apb(1'b1, `PRDM_OFS_CONTROL, rd2);
    repeat (4) @(posedge clk);
    apb(1'b0, `PRDM_OFS_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b1);
    $display("test 9 done");
    endSim;
  end
endmodule
